/* File: hdl/ski_consts.svh */
// constants of the serial, keyboard and interrupt register block
`ifndef SKI_CONSTS_SVH
`define SKI_CONSTS_SVH

// ***********************************
// register indexes (byte address = 4 * index)
// ***********************************
`define SKI_IDX_RX_BUF     16'hFF00
`define SKI_IDX_KBD_IN     16'hFF01
`define SKI_IDX_IRQ_VEC    16'hFF02
`define SKI_IDX_STATUS     16'hFF03
`define SKI_IDX_COMMAND    16'hFF04
`define SKI_IDX_RATE       16'hFF05
`define SKI_IDX_TX_DATA    16'hFF06
`define SKI_IDX_KBD_OUT    16'hFF07
`define SKI_IDX_IRQ_MASK   16'hFF08

// ***********************************
// field positions
// ***********************************
`define SKI_RATE_ONE_STOP  7
`define SKI_MASK_RX_BIT    0
`define SKI_MASK_TX_BIT    1
`define SKI_KBD_AUX_BIT    7

// ***********************************
// rate codes, low seven bits, one-hot
// ***********************************
`define SKI_RATE_110       7'h01
`define SKI_RATE_150       7'h02
`define SKI_RATE_300       7'h04
`define SKI_RATE_1200      7'h08
`define SKI_RATE_2400      7'h10
`define SKI_RATE_4800      7'h20
`define SKI_RATE_9600      7'h40

// ***********************************
// reset values and vectors
// ***********************************
`define SKI_RST_RATE       8'hC0
`define SKI_RST_COMMAND    8'h00
`define SKI_RST_MASK       8'h00
`define SKI_RST_KBD_OUT    8'h00
`define SKI_VEC_RX         8'h20
`define SKI_VEC_TX         8'h28

// ***********************************
// timing
// ***********************************
`define SKI_CLK_HZ         125000000
`define SKI_OVERSAMPLE     16
`define SKI_BAUD_110       110
`define SKI_BAUD_150       150
`define SKI_BAUD_300       300
`define SKI_BAUD_1200      1200
`define SKI_BAUD_2400      2400
`define SKI_BAUD_4800      4800
`define SKI_BAUD_9600      9600
`define SKI_MID_SAMPLE     4'h7
`define SKI_LAST_SAMPLE    4'hF

`endif

/* File: hdl/ski_pkg.sv */
// types of the serial, keyboard and interrupt register block
package ski_pkg;

   typedef enum logic [1:0] {
      SKI_TX_IDLE,
      SKI_TX_START,
      SKI_TX_DATA,
      SKI_TX_STOP
   } ski_tx_state_t;

   typedef enum logic [1:0] {
      SKI_RX_IDLE,
      SKI_RX_START,
      SKI_RX_DATA,
      SKI_RX_STOP
   } ski_rx_state_t;

   typedef struct packed {
      logic [2:0] unused;
      logic       tx_ready;
      logic       rx_loaded;
      logic       overrun;
      logic       frame_err;
      logic       zero;
   } ski_status_t;

endpackage

/* File: hdl/ski_serial_keyboard_io.sv */
// serial port, keyboard ports and interrupt registers behind classic wishbone
// How it works
// - receive buffer read returns the last character received
// - keyboard input read gives matrix data bits 0..6, aux line bit 7
// - keyboard input bit 7 follows the page blanking wired to the aux line
// - status bit 4 is one while the transmitter can take a character
// - receive-loaded status flag sets when a full character lands in the buffer
// - overrun flag sets when a character arrives before the last was read
// - status bit 1 flags framing error, set by a break on the input
// - rate register one-hot code in bits 0..6 selects the bit rate
// - rate bit 7 clear gives two stop bits, set gives one
// - keyboard output writes drive the scan lines; reads return nothing
// - receive-ready and transmit-ready raise interrupts vectored to 20h and 28h
// - output halts between characters while terminal-ready is low
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ski_consts.svh"

module ski_serial_keyboard_io #(
   parameter int DIV_110  = `SKI_CLK_HZ / (`SKI_BAUD_110  * `SKI_OVERSAMPLE),
   parameter int DIV_150  = `SKI_CLK_HZ / (`SKI_BAUD_150  * `SKI_OVERSAMPLE),
   parameter int DIV_300  = `SKI_CLK_HZ / (`SKI_BAUD_300  * `SKI_OVERSAMPLE),
   parameter int DIV_1200 = `SKI_CLK_HZ / (`SKI_BAUD_1200 * `SKI_OVERSAMPLE),
   parameter int DIV_2400 = `SKI_CLK_HZ / (`SKI_BAUD_2400 * `SKI_OVERSAMPLE),
   parameter int DIV_4800 = `SKI_CLK_HZ / (`SKI_BAUD_4800 * `SKI_OVERSAMPLE),
   parameter int DIV_9600 = `SKI_CLK_HZ / (`SKI_BAUD_9600 * `SKI_OVERSAMPLE)
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [17:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        serial_rx_i,
   output logic             serial_tx_o,
   input  wire logic        term_ready_i,
   input  wire logic [6:0]  kbd_cols_i,
   input  wire logic        aux_bus_input_line_i,
   output logic      [7:0]  kbd_rows_o,
   output logic             irq_o
);
   import ski_pkg::*;

   // ***********************************
   // pin synchronisers
   // ***********************************
   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic       rx_s;
   logic       dtr_s;
   logic [7:0] kbd_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 10'h3FF;
         sync2_r <= 10'h3FF;
      end else begin
         sync1_r <= {aux_bus_input_line_i, kbd_cols_i, term_ready_i, serial_rx_i};
         sync2_r <= sync1_r;
      end
   end

   assign rx_s  = sync2_r[0];
   assign dtr_s = sync2_r[1];
   assign kbd_s = sync2_r[9:2];

   // ***********************************
   // bus decode
   // ***********************************
   logic [15:0] idx;
   logic        acc;
   logic        wr_lo;
   logic        rd_rxbuf;
   logic        wr_txdata;

   assign idx       = wb_adr_i[17:2];
   assign acc       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lo     = acc & wb_we_i & wb_sel_i[0];
   assign rd_rxbuf  = acc & ~wb_we_i & (idx == `SKI_IDX_RX_BUF);
   assign wr_txdata = wr_lo & (idx == `SKI_IDX_TX_DATA);

   // ***********************************
   // bit rate tick
   // ***********************************
   logic [7:0]  rate_r;
   logic [16:0] div_sel;
   logic [16:0] tick_cnt_r;
   logic [16:0] tick_cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;

   always_comb begin
      case (rate_r[6:0])
         `SKI_RATE_110:  div_sel = 17'(DIV_110);
         `SKI_RATE_150:  div_sel = 17'(DIV_150);
         `SKI_RATE_300:  div_sel = 17'(DIV_300);
         `SKI_RATE_1200: div_sel = 17'(DIV_1200);
         `SKI_RATE_2400: div_sel = 17'(DIV_2400);
         `SKI_RATE_4800: div_sel = 17'(DIV_4800);
         // codes outside the table fall back to the fastest rate
         default:        div_sel = 17'(DIV_9600);
      endcase
      tick_nxt     = 1'b0;
      tick_cnt_nxt = tick_cnt_r + 17'h00001;
      if (tick_cnt_r >= div_sel - 17'h00001) begin
         tick_cnt_nxt = 17'h00000;
         tick_nxt     = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_r <= 17'h00000;
         tick_r     <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         tick_r     <= tick_nxt;
      end
   end

   // ***********************************
   // receiver
   // ***********************************
   ski_rx_state_t rx_st_r;
   ski_rx_state_t rx_st_nxt;
   logic [3:0]    rx_smp_r;
   logic [3:0]    rx_smp_nxt;
   logic [2:0]    rx_bit_r;
   logic [2:0]    rx_bit_nxt;
   logic [7:0]    rx_sh_r;
   logic [7:0]    rx_sh_nxt;
   logic          rx_done;
   logic          rx_bad;
   logic          rx_hi_r;
   logic          rx_hi_nxt;

   always_comb begin
      rx_st_nxt  = rx_st_r;
      rx_smp_nxt = rx_smp_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt  = rx_sh_r;
      rx_done    = 1'b0;
      rx_bad     = 1'b0;
      rx_hi_nxt  = rx_hi_r;
      if (tick_r) begin
         rx_smp_nxt = rx_smp_r + 4'h1;
         rx_hi_nxt  = rx_s;
         case (rx_st_r)
            SKI_RX_IDLE: begin
               rx_smp_nxt = 4'h0;
               // a break must see the line high again before a new start counts
               if (!rx_s && rx_hi_r) begin
                  rx_st_nxt = SKI_RX_START;
               end
            end
            SKI_RX_START: begin
               // recheck at mid bit so a glitch does not start a frame
               if (rx_smp_r == `SKI_MID_SAMPLE) begin
                  rx_smp_nxt = 4'h0;
                  rx_bit_nxt = 3'h0;
                  rx_st_nxt  = rx_s ? SKI_RX_IDLE : SKI_RX_DATA;
               end
            end
            SKI_RX_DATA: begin
               if (rx_smp_r == `SKI_LAST_SAMPLE) begin
                  rx_sh_nxt  = {rx_s, rx_sh_r[7:1]};
                  rx_bit_nxt = rx_bit_r + 3'h1;
                  if (rx_bit_r == 3'h7) begin
                     rx_st_nxt = SKI_RX_STOP;
                  end
               end
            end
            SKI_RX_STOP: begin
               if (rx_smp_r == `SKI_LAST_SAMPLE) begin
                  rx_done   = 1'b1;
                  rx_bad    = ~rx_s;
                  rx_st_nxt = SKI_RX_IDLE;
               end
            end
            default: rx_st_nxt = SKI_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_r  <= SKI_RX_IDLE;
         rx_smp_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r  <= 8'h00;
         rx_hi_r  <= 1'b1;
      end else begin
         rx_st_r  <= rx_st_nxt;
         rx_smp_r <= rx_smp_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r  <= rx_sh_nxt;
         rx_hi_r  <= rx_hi_nxt;
      end
   end

   // ***********************************
   // transmitter
   // ***********************************
   ski_tx_state_t tx_st_r;
   ski_tx_state_t tx_st_nxt;
   logic [3:0]    tx_smp_r;
   logic [3:0]    tx_smp_nxt;
   logic [2:0]    tx_bit_r;
   logic [2:0]    tx_bit_nxt;
   logic [7:0]    tx_sh_r;
   logic [7:0]    tx_sh_nxt;
   logic          tx_pend_r;
   logic          tx_pend_nxt;
   logic          tx_stop2_r;
   logic          tx_stop2_nxt;
   logic          tx_line_nxt;

   always_comb begin
      tx_st_nxt    = tx_st_r;
      tx_smp_nxt   = tx_smp_r;
      tx_bit_nxt   = tx_bit_r;
      tx_sh_nxt    = tx_sh_r;
      tx_pend_nxt  = tx_pend_r;
      tx_stop2_nxt = tx_stop2_r;
      if (wr_txdata && !tx_pend_r) begin
         tx_sh_nxt   = wb_dat_i[7:0];
         tx_pend_nxt = 1'b1;
      end
      if (tick_r) begin
         tx_smp_nxt = tx_smp_r + 4'h1;
         case (tx_st_r)
            SKI_TX_IDLE: begin
               tx_smp_nxt = 4'h0;
               // only start on a sample tick, held off by terminal-ready
               if (tx_pend_r && dtr_s) begin
                  tx_st_nxt    = SKI_TX_START;
                  tx_stop2_nxt = ~rate_r[`SKI_RATE_ONE_STOP];
               end
            end
            SKI_TX_START: begin
               if (tx_smp_r == `SKI_LAST_SAMPLE) begin
                  tx_bit_nxt = 3'h0;
                  tx_st_nxt  = SKI_TX_DATA;
               end
            end
            SKI_TX_DATA: begin
               if (tx_smp_r == `SKI_LAST_SAMPLE) begin
                  tx_sh_nxt  = {1'b1, tx_sh_r[7:1]};
                  tx_bit_nxt = tx_bit_r + 3'h1;
                  if (tx_bit_r == 3'h7) begin
                     tx_st_nxt = SKI_TX_STOP;
                  end
               end
            end
            SKI_TX_STOP: begin
               if (tx_smp_r == `SKI_LAST_SAMPLE) begin
                  if (tx_stop2_r) begin
                     tx_stop2_nxt = 1'b0;
                  end else begin
                     tx_st_nxt   = SKI_TX_IDLE;
                     tx_pend_nxt = 1'b0;
                  end
               end
            end
            default: tx_st_nxt = SKI_TX_IDLE;
         endcase
      end
      case (tx_st_nxt)
         SKI_TX_START: tx_line_nxt = 1'b0;
         SKI_TX_DATA:  tx_line_nxt = tx_sh_nxt[0];
         default:      tx_line_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_r     <= SKI_TX_IDLE;
         tx_smp_r    <= 4'h0;
         tx_bit_r    <= 3'h0;
         tx_sh_r     <= 8'h00;
         tx_pend_r   <= 1'b0;
         tx_stop2_r  <= 1'b0;
         serial_tx_o <= 1'b1;
      end else begin
         tx_st_r     <= tx_st_nxt;
         tx_smp_r    <= tx_smp_nxt;
         tx_bit_r    <= tx_bit_nxt;
         tx_sh_r     <= tx_sh_nxt;
         tx_pend_r   <= tx_pend_nxt;
         tx_stop2_r  <= tx_stop2_nxt;
         serial_tx_o <= tx_line_nxt;
      end
   end

   // ***********************************
   // registers, status and bus answer
   // ***********************************
   logic [7:0]  rx_buf_r;
   logic [7:0]  rx_buf_nxt;
   ski_status_t st_r;
   ski_status_t st_nxt;
   logic [7:0]  rate_nxt;
   logic [7:0]  cmd_r;
   logic [7:0]  cmd_nxt;
   logic [7:0]  mask_r;
   logic [7:0]  mask_nxt;
   logic [7:0]  rows_nxt;
   logic [7:0]  vec;
   logic        irq_rx;
   logic        irq_tx;
   logic [31:0] rdat;

   assign irq_rx = st_r.rx_loaded & mask_r[`SKI_MASK_RX_BIT];
   assign irq_tx = st_r.tx_ready & mask_r[`SKI_MASK_TX_BIT];
   assign vec    = irq_rx ? `SKI_VEC_RX : `SKI_VEC_TX;

   always_comb begin
      rx_buf_nxt = rx_buf_r;
      st_nxt     = st_r;
      rate_nxt   = rate_r;
      cmd_nxt    = cmd_r;
      mask_nxt   = mask_r;
      rows_nxt   = kbd_rows_o;
      // read clears first so a same-cycle arrival wins
      if (rd_rxbuf) begin
         st_nxt.rx_loaded = 1'b0;
         st_nxt.overrun   = 1'b0;
         st_nxt.frame_err = 1'b0;
      end
      if (rx_done) begin
         rx_buf_nxt       = rx_sh_r;
         st_nxt.rx_loaded = 1'b1;
         st_nxt.overrun   = st_r.rx_loaded & ~rd_rxbuf;
         st_nxt.frame_err = rx_bad;
      end
      st_nxt.tx_ready = ~tx_pend_nxt;
      st_nxt.unused   = 3'h0;
      st_nxt.zero     = 1'b0;
      if (wr_lo) begin
         case (idx)
            `SKI_IDX_RATE:     rate_nxt = wb_dat_i[7:0];
            `SKI_IDX_COMMAND:  cmd_nxt  = wb_dat_i[7:0];
            `SKI_IDX_IRQ_MASK: mask_nxt = wb_dat_i[7:0];
            `SKI_IDX_KBD_OUT:  rows_nxt = wb_dat_i[7:0];
            default:           rows_nxt = kbd_rows_o;
         endcase
      end
      case (idx)
         `SKI_IDX_RX_BUF:   rdat = {24'h000000, rx_buf_r};
         `SKI_IDX_KBD_IN:   rdat = {24'h000000, kbd_s};
         `SKI_IDX_IRQ_VEC:  rdat = {24'h000000, vec};
         `SKI_IDX_STATUS:   rdat = {24'h000000, st_r};
         `SKI_IDX_COMMAND:  rdat = {24'h000000, cmd_r};
         `SKI_IDX_IRQ_MASK: rdat = {24'h000000, mask_r};
         default:           rdat = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_buf_r   <= 8'h00;
         st_r       <= '0;
         rate_r     <= `SKI_RST_RATE;
         cmd_r      <= `SKI_RST_COMMAND;
         mask_r     <= `SKI_RST_MASK;
         kbd_rows_o <= `SKI_RST_KBD_OUT;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h00000000;
         irq_o      <= 1'b0;
      end else begin
         rx_buf_r   <= rx_buf_nxt;
         st_r       <= st_nxt;
         rate_r     <= rate_nxt;
         cmd_r      <= cmd_nxt;
         mask_r     <= mask_nxt;
         kbd_rows_o <= rows_nxt;
         wb_ack_o   <= acc;
         wb_dat_o   <= (acc && !wb_we_i) ? rdat : 32'h00000000;
         irq_o      <= irq_rx | irq_tx;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   a_rx_load_flag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_done |=> st_r.rx_loaded && (rx_buf_r == $past(rx_sh_r)))
      else $error("received character not loaded");

   a_overrun_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_done && st_r.rx_loaded && !rd_rxbuf |=> st_r.overrun)
      else $error("overrun not flagged");

   a_read_clears: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rd_rxbuf && !rx_done |=> !st_r.rx_loaded && !st_r.overrun)
      else $error("buffer read left flag set");

   a_frame_break: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_done && !rx_s |=> st_r.frame_err)
      else $error("break not flagged as frame error");

   a_ready_drops: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_txdata && st_r.tx_ready |=> !st_r.tx_ready ##1 !st_r.tx_ready)
      else $error("ready stayed high after transmit write");

   a_dtr_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_st_r == SKI_TX_IDLE && !dtr_s |=> tx_st_r == SKI_TX_IDLE)
      else $error("transmit started while terminal not ready");

   a_tx_start_low: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_st_r == SKI_TX_START |-> !serial_tx_o)
      else $error("start bit not low");

   a_bus_ack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      acc |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");

   a_kbd_aux: assert property (
      @(posedge clk_i) disable iff (rst_i)
      acc && !wb_we_i && idx == `SKI_IDX_KBD_IN |=> wb_dat_o[7] == $past(kbd_s[7]))
      else $error("keyboard bit 7 not the aux line");

   a_irq_rx: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.rx_loaded && mask_r[0] |=> irq_o)
      else $error("receive interrupt missing");

endmodule

/* File: verif/ski_term_peer.sv */
// serial terminal model at the far end of the serial lines
`timescale 1ns/1ps

module ski_term_peer (
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      line_o
);
   int         bit_cyc = 64;
   logic [7:0] got_q[$];

   initial begin
      line_o = 1'b1;
   end

   // ******************************
   // sender: lsb first, stop level chosen to make a break
   // ******************************
   task automatic send(input logic [7:0] d, input logic stop_v);
      logic [9:0] f;
      f = {stop_v, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_o <= f[i];
         repeat (bit_cyc) @(posedge clk_i);
      end
      // mark level between characters, as a real line idles
      line_o <= 1'b1;
      repeat (bit_cyc) @(posedge clk_i);
   endtask

   // ******************************
   // receiver: samples mid bit
   // ******************************
   initial begin
      logic [7:0] d;
      forever begin
         @(negedge line_i);
         repeat (bit_cyc / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_i);
            d[i] = line_i;
         end
         repeat (bit_cyc) @(posedge clk_i);
         got_q.push_back(d);
      end
   end
endmodule

/* File: verif/testbench.sv */
// register-level testbench of the serial and keyboard block
`timescale 1ns/1ps
`include "ski_consts.svh"

module testbench;
   import ski_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, rx, tx, trdy, aux, irq;
   logic [17:0] adr;
   logic [31:0] dat_w, dat_r;
   logic [6:0]  cols;
   logic [7:0]  rows, q, code;
   logic [3:0]  sel, sel_v;
   int          err_total = 0;
   int          total_checks = 0;
   // shortened 16x divisors keep every rate inside the cycle budget
   localparam int DV [7] = '{12, 11, 10, 9, 7, 6, 4};
   int          m, ex;

   ski_serial_keyboard_io #(.DIV_110(DV[0]), .DIV_150(DV[1]), .DIV_300(DV[2]),
      .DIV_1200(DV[3]), .DIV_2400(DV[4]), .DIV_4800(DV[5]), .DIV_9600(DV[6])) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .serial_rx_i(rx), .serial_tx_o(tx), .term_ready_i(trdy),
      .kbd_cols_i(cols), .aux_bus_input_line_i(aux), .kbd_rows_o(rows), .irq_o(irq));

   ski_term_peer peer (.clk_i(clk_i), .line_i(tx), .line_o(rx));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ******************************
   // bus and compare tasks
   // ******************************
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask

   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; dat_w <= {24'h0, d};
      sel <= sel_v;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_r[7:0];
      if (n >= 50) check("ack", 8'h00, 8'h01);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] i, input logic [7:0] e, input string n);
      wb(1'b0, i, 8'h00);
      check(n, q, e);
   endtask

   // polls status with a bounded count; long frames at slow rates fit easily
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do begin
         wb(1'b0, `SKI_IDX_STATUS, 8'h00);
         n++;
      end while (q[b] !== v && n < 3000);
      check("status bit", 8'(q[b]), 8'(v));
   endtask

   task automatic peer_byte(input logic [7:0] e);
      check("peer count", 8'(peer.got_q.size()), 8'h01);
      if (peer.got_q.size() > 0) check("peer byte", peer.got_q.pop_front(), e);
   endtask

   // ******************************
   // main sequence
   // ******************************
   initial begin
      cyc = 0; stb = 0; we = 0; adr = 0; dat_w = 0; rst_i = 1; trdy = 1; aux = 0; cols = 0;
      sel = 4'hF;
      sel_v = 4'hF;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`SKI_IDX_STATUS, 8'h10, "status");
      rd(`SKI_IDX_RATE, 8'h00, "rate rd");
      rd(`SKI_IDX_TX_DATA, 8'h00, "tx rd");
      rd(`SKI_IDX_KBD_OUT, 8'h00, "scan rd");
      rd(16'hFF0F, 8'h00, "unmapped");
      wb(1'b1, `SKI_IDX_STATUS, 8'hFF);
      wb(1'b1, `SKI_IDX_RX_BUF, 8'h55);
      rd(`SKI_IDX_STATUS, 8'h10, "status ro");
      wb(1'b1, `SKI_IDX_COMMAND, 8'h5A);
      rd(`SKI_IDX_COMMAND, 8'h5A, "command");
      // a write without the low byte lane enabled must leave the register alone
      sel_v = 4'hE;
      wb(1'b1, `SKI_IDX_COMMAND, 8'hA5);
      sel_v = 4'hF;
      rd(`SKI_IDX_COMMAND, 8'h5A, "sel gate");
      cols <= 7'h55; aux <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(`SKI_IDX_KBD_IN, 8'hD5, "kbd in");
      cols <= 7'h2A; aux <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(`SKI_IDX_KBD_IN, 8'h2A, "kbd in");
      wb(1'b1, `SKI_IDX_KBD_OUT, 8'hA5);
      check("rows", rows, 8'hA5);
      // transmit held off by terminal not ready
      trdy <= 1'b0;
      wb(1'b1, `SKI_IDX_TX_DATA, 8'h5A);
      rd(`SKI_IDX_STATUS, 8'h00, "tx busy");
      repeat (400) @(posedge clk_i);
      check("tx held", 8'(tx), 8'h01);
      trdy <= 1'b1;
      wait_st(4, 1'b1);
      peer_byte(8'h5A);
      // receive, clear on read, overrun, break
      peer.send(8'h3C, 1'b1);
      wait_st(3, 1'b1);
      rd(`SKI_IDX_RX_BUF, 8'h3C, "rx buf");
      rd(`SKI_IDX_STATUS, 8'h10, "rx clr");
      peer.send(8'h81, 1'b1);
      peer.send(8'h7E, 1'b1);
      wait_st(2, 1'b1);
      rd(`SKI_IDX_RX_BUF, 8'h7E, "rx last");
      rd(`SKI_IDX_STATUS, 8'h10, "ovr clr");
      peer.send(8'h00, 1'b0);
      wait_st(1, 1'b1);
      rd(`SKI_IDX_RX_BUF, 8'h00, "rx brk");
      // interrupt sources and vectors
      wb(1'b1, `SKI_IDX_IRQ_MASK, 8'h01);
      peer.send(8'h42, 1'b1);
      wait_st(3, 1'b1);
      repeat (3) @(posedge clk_i);
      check("irq rx", 8'(irq), 8'h01);
      rd(`SKI_IDX_IRQ_VEC, `SKI_VEC_RX, "vec rx");
      rd(`SKI_IDX_RX_BUF, 8'h42, "rx buf");
      repeat (3) @(posedge clk_i);
      check("irq off", 8'(irq), 8'h00);
      wb(1'b1, `SKI_IDX_IRQ_MASK, 8'h02);
      rd(`SKI_IDX_IRQ_VEC, `SKI_VEC_TX, "vec tx");
      repeat (3) @(posedge clk_i);
      check("irq tx", 8'(irq), 8'h01);
      // every rate code in both stop-bit forms; frame length from start edge to ready
      for (int k = 0; k < 14; k++) begin
         code = {k[0], 7'(1 << (k / 2))};
         wb(1'b1, `SKI_IDX_RATE, code);
         peer.bit_cyc = 16 * DV[k / 2];
         wb(1'b1, `SKI_IDX_TX_DATA, 8'hFF);
         m = 0;
         while (tx !== 1'b0 && m < 5000) begin
            @(posedge clk_i);
            m++;
         end
         m = 0;
         while (irq !== 1'b1 && m < 5000) begin
            @(posedge clk_i);
            m++;
         end
         ex = (code[7] ? 10 : 11) * 16 * DV[k / 2];
         check("frame len", 8'(m > ex - 5 && m < ex + 5), 8'h01);
         peer_byte(8'hFF);
      end
      report_and_stop();
   end

   // hang guard: the sequence needs roughly 25000 cycles
   initial begin
      repeat (90000) @(posedge clk_i);
      check("timeout", 8'h00, 8'h01);
      report_and_stop();
   end
endmodule
